// ### rtl/fac_defs.svh
`ifndef FAC_DEFS_SVH
`define FAC_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FAC_OFF_CTRL 8'h00
`define FAC_OFF_PROC_DEC 8'h04
`define FAC_OFF_REC_DEC 8'h08
`define FAC_OFF_REC_LEN 8'h0c
`define FAC_OFF_GROW_LEN 8'h10
`define FAC_OFF_HOLDOFF 8'h14
`define FAC_OFF_SAT_THR 8'h18
`define FAC_OFF_CMD 8'h1c
`define FAC_OFF_STATUS 8'h20
`define FAC_OFF_SAT_POLL 8'h24
`define FAC_OFF_CAP_CNT 8'h28

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define FAC_CTRL_FB_ON 0
`define FAC_CTRL_COEF 1
`define FAC_CTRL_GAIN_LO 2
`define FAC_CTRL_GAIN_HI 4
`define FAC_CTRL_SWAP 8
`define FAC_CTRL_TRIG_SRC 9
`define FAC_CTRL_REARM 10
`define FAC_CTRL_MEM 11

// ----------------------------------------
// Command register pulse bits
// ----------------------------------------
`define FAC_CMD_TRIG 0
`define FAC_CMD_ARM 1
`define FAC_CMD_READOUT 2

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define FAC_ST_HEALTH_LO 0
`define FAC_ST_HEALTH_HI 3
`define FAC_ST_SAT 4
`define FAC_ST_ARMED 5
`define FAC_ST_BUSY 6
`define FAC_ST_DONE 7

// ----------------------------------------
// Limits, widths and bus constants
// ----------------------------------------
`define FAC_BRAM_LIMIT 24'd131072
`define FAC_SRAM_LIMIT 24'd8388608
`define FAC_HOLD_GROUP 2
`define FAC_HTRANS_ACTIVE 1
`define FAC_ADDR_HI 7
`define FAC_ADDR_LO 2
`define FAC_SAT_FRAC_W 16
`define FAC_RESP_OKAY 1'b0

`endif

// ### rtl/fac_pkg.sv
package fac_pkg;

	// Acquisition sequencer states
	typedef enum logic [1:0] {FAC_IDLE, FAC_HOLD, FAC_REC} fac_acq_e;

	// AHB-Lite request from the master
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} fac_ahb_req_s;

	// Filter output sample stream
	typedef struct packed {
		logic valid;
		logic saturated;
		logic [15:0] data;
	} fac_sample_s;

	// Asynchronous health indicators
	typedef struct packed {
		logic fiducial_error;
		logic capture_clock_manager_unlocked;
		logic processing_clock_manager_unlocked;
		logic rf_clock_missing;
	} fac_health_s;

	// Capture memory write port
	typedef struct packed {
		logic we_bram;
		logic we_sram;
		logic [22:0] addr;
		logic [15:0] data;
	} fac_cap_s;

	// Decimator state
	typedef struct packed {
		logic [7:0] cnt;
	} fac_dec_s;

	// Saturation monitor state
	typedef struct packed {
		logic [23:0] sat_cnt;
		logic [23:0] total_cnt;
	} fac_sat_s;

	// Top-level state
	typedef struct packed {
		logic feedback_on;
		logic coef_set;
		logic [2:0] gain_shift;
		logic coef_swap_enable;
		logic trigger_source_select;
		logic automatic_rearm;
		logic capture_memory_select;
		logic [7:0] proc_decimation;
		logic [7:0] record_decimation;
		logic [23:0] rec_len;
		logic [23:0] grow_len;
		logic [15:0] holdoff;
		logic [15:0] sat_thresh;
		logic [1:0] trig_sync;
		logic trig_prev;
		fac_health_s health_meta;
		fac_health_s health_sync;
		logic armed;
		fac_acq_e acq;
		logic [17:0] phase_cnt;
		logic [23:0] rec_cnt;
		logic done;
		logic [15:0] dac_data;
		fac_cap_s cap;
		logic write_ph;
		logic [7:0] addr;
		logic [31:0] hrdata;
	} fac_top_s;

endpackage

// ### rtl/fac_decimator.sv
`timescale 1ns/100ps
`default_nettype none

module fac_decimator (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic VALID,
	input wire logic [7:0] FACTOR,
	output logic STROBE
);
	import fac_pkg::*;

	fac_dec_s s; // Registered state
	fac_dec_s n; // Next state

	// ----------------------------------------
	// One strobe every FACTOR valid samples
	// ----------------------------------------
	// pick every Nth sample
	assign STROBE = VALID && (s.cnt == 8'h00);

	// Countdown to the next kept sample
	always_comb begin
		n = s;
		if (VALID) begin
			if (s.cnt != 8'h00) begin
				n.cnt = s.cnt - 8'h01;
			end else if (FACTOR > 8'h01) begin
				n.cnt = FACTOR - 8'h01;
			end
		end
	end

	// State register
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// no back-to-back strobes when factor above one
	AST_DEC_SPACING: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) (STROBE && FACTOR > 8'h01 && $stable(FACTOR)) |=> !STROBE) else $error("Decimator strobed twice in a row");
endmodule

`default_nettype wire

// ### rtl/fac_sat_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "fac_defs.svh"

module fac_sat_monitor (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic VALID,
	input wire logic SATURATED,
	input wire logic CLEAR,
	input wire logic [15:0] THRESH,
	output logic FLAG
);
	import fac_pkg::*;

	fac_sat_s s; // Registered counters
	fac_sat_s n; // Next counters
	logic sat_ev; // Saturated sample this cycle
	logic [39:0] scaled_sat; // Saturated count in duty units
	logic [39:0] scaled_thr; // Threshold times sample count

	// ----------------------------------------
	// Duty-cycle comparison
	// ----------------------------------------
	assign sat_ev = VALID && SATURATED;
	assign scaled_sat = {s.sat_cnt, {`FAC_SAT_FRAC_W{1'b0}}};
	assign scaled_thr = 40'(THRESH) * 40'(s.total_cnt);
	// zero threshold flags any single event
	assign FLAG = scaled_sat > scaled_thr;

	// Integrating counters, saturating at full scale
	always_comb begin
		n = s;
		if (CLEAR) begin
			n.sat_cnt = '0;
			n.total_cnt = '0;
		end
		// integrate saturated time, new event beats clear
		if (sat_ev && !(&n.sat_cnt)) begin
			n.sat_cnt = n.sat_cnt + 24'h1;
		end
		if (VALID && !(&n.total_cnt)) begin
			n.total_cnt = n.total_cnt + 24'h1;
		end
	end

	// State register
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	AST_SAT_ZERO_THR: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) (THRESH == 16'h0000 && sat_ev && $stable(THRESH)) |=> FLAG) else $error("Single saturation not flagged at zero threshold");
	AST_SAT_CLEAR: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) (CLEAR && !sat_ev) |=> (!FLAG && s.sat_cnt == 24'h0)) else $error("Poll read did not clear saturation count");
endmodule

`default_nettype wire

// ### rtl/fac_top.sv
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "fac_defs.svh"

module fac_top (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire fac_pkg::fac_ahb_req_s AHB_REQ,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire fac_pkg::fac_sample_s SAMPLE,
	output logic [15:0] DAC_DATA,
	output logic PROC_STROBE,
	output logic COEF_SET,
	input wire logic EXTERNAL_TRIGGER_INPUT,
	input wire fac_pkg::fac_health_s HEALTH,
	output var fac_pkg::fac_cap_s CAP
);
	import fac_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	fac_top_s s; // Registered state
	fac_top_s n; // Next state
	logic proc_strobe; // Processing path sample kept
	logic rec_strobe; // Capture path sample kept
	logic filter_saturation_flag; // Duty above threshold
	logic sat_clear; // Poll read of the saturation result
	logic addr_act; // Valid address phase this cycle
	logic [7:0] addr_in; // Word-aligned offset of request
	logic soft_trig; // Software trigger pulse
	logic arm_cmd; // Arm pulse
	logic readout_cmd; // Readout finished pulse
	logic ext_edge; // Rising edge of external trigger
	logic trig_ok; // Accepted trigger in idle
	logic [23:0] eff_len; // Record length after memory cap
	logic [23:0] mem_limit; // Cap of selected memory
	logic invert; // Coefficient select inverted
	logic [15:0] scaled; // Gain-shifted, clamped sample

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Gain by arithmetic shift, clamped to the output range
	function automatic logic [15:0] apply_gain(logic [15:0] d, logic [2:0] sh);
		logic signed [31:0] w;
		w = 32'(signed'(d)) <<< sh;
		if (w > 32'sh00007fff) begin
			apply_gain = 16'h7fff;
		end else if (w < -32'sh00008000) begin
			apply_gain = 16'h8000;
		end else begin
			apply_gain = w[15:0];
		end
	endfunction

	// Read data for one register offset
	function automatic logic [31:0] read_word(fac_top_s r, logic [7:0] a, logic flag);
		logic [31:0] w;
		w = '0;
		unique case (a)
			`FAC_OFF_CTRL: begin
				w[`FAC_CTRL_FB_ON] = r.feedback_on;
				w[`FAC_CTRL_COEF] = r.coef_set;
				w[`FAC_CTRL_GAIN_HI:`FAC_CTRL_GAIN_LO] = r.gain_shift;
				w[`FAC_CTRL_SWAP] = r.coef_swap_enable;
				w[`FAC_CTRL_TRIG_SRC] = r.trigger_source_select;
				w[`FAC_CTRL_REARM] = r.automatic_rearm;
				w[`FAC_CTRL_MEM] = r.capture_memory_select;
			end
			`FAC_OFF_PROC_DEC: w[7:0] = r.proc_decimation;
			`FAC_OFF_REC_DEC: w[7:0] = r.record_decimation;
			`FAC_OFF_REC_LEN: w[23:0] = r.rec_len;
			`FAC_OFF_GROW_LEN: w[23:0] = r.grow_len;
			`FAC_OFF_HOLDOFF: w[15:0] = r.holdoff;
			`FAC_OFF_SAT_THR: w[15:0] = r.sat_thresh;
			`FAC_OFF_STATUS: begin
				w[`FAC_ST_HEALTH_HI:`FAC_ST_HEALTH_LO] = r.health_sync;
				w[`FAC_ST_SAT] = flag;
				w[`FAC_ST_ARMED] = r.armed;
				w[`FAC_ST_BUSY] = (r.acq != FAC_IDLE);
				w[`FAC_ST_DONE] = r.done;
			end
			`FAC_OFF_SAT_POLL: w[`FAC_ST_SAT] = flag;
			`FAC_OFF_CAP_CNT: w[23:0] = r.rec_cnt;
			default: w = '0;
		endcase
		read_word = w;
	endfunction

	// ----------------------------------------
	// Decimators and saturation monitor
	// ----------------------------------------
	// processing path decimation
	fac_decimator u_proc_dec (
		.SYS_CLK(SYS_CLK),
		.SYS_RST(SYS_RST),
		.VALID(SAMPLE.valid),
		.FACTOR(s.proc_decimation),
		.STROBE(proc_strobe)
	);

	// separate counter for the capture path
	fac_decimator u_rec_dec (
		.SYS_CLK(SYS_CLK),
		.SYS_RST(SYS_RST),
		.VALID(SAMPLE.valid),
		.FACTOR(s.record_decimation),
		.STROBE(rec_strobe)
	);

	fac_sat_monitor u_sat (
		.SYS_CLK(SYS_CLK),
		.SYS_RST(SYS_RST),
		.VALID(SAMPLE.valid),
		.SATURATED(SAMPLE.saturated),
		.CLEAR(sat_clear),
		.THRESH(s.sat_thresh),
		.FLAG(filter_saturation_flag)
	);

	// ----------------------------------------
	// Derived terms
	// ----------------------------------------
	assign addr_act = AHB_REQ.hsel && AHB_REQ.hready && AHB_REQ.htrans[`FAC_HTRANS_ACTIVE];
	assign addr_in = {AHB_REQ.haddr[`FAC_ADDR_HI:`FAC_ADDR_LO], 2'b00};
	// reading the poll register clears the integrator
	assign sat_clear = addr_act && !AHB_REQ.hwrite && (addr_in == `FAC_OFF_SAT_POLL);
	// Edge from the second synchroniser stage only
	assign ext_edge = s.trig_sync[1] && !s.trig_prev;
	// cap the length by the memory in use
	assign mem_limit = s.capture_memory_select ? `FAC_SRAM_LIMIT : `FAC_BRAM_LIMIT;
	assign eff_len = (s.rec_len > mem_limit) ? mem_limit : s.rec_len;
	// inversion during hold-off and the first grow samples
	assign invert = (s.acq == FAC_HOLD) ||
		(s.acq == FAC_REC && s.coef_swap_enable && s.rec_cnt < s.grow_len);
	assign scaled = apply_gain(SAMPLE.data, s.gain_shift);

	// Command pulses come from the data phase of a write
	always_comb begin
		soft_trig = 1'b0;
		arm_cmd = 1'b0;
		readout_cmd = 1'b0;
		if (s.write_ph && s.addr == `FAC_OFF_CMD) begin
			soft_trig = AHB_REQ.hwdata[`FAC_CMD_TRIG];
			arm_cmd = AHB_REQ.hwdata[`FAC_CMD_ARM];
			readout_cmd = AHB_REQ.hwdata[`FAC_CMD_READOUT];
		end
	end

	// internal start is the software command
	assign trig_ok = (s.acq == FAC_IDLE) &&
		(s.trigger_source_select ? (ext_edge && s.armed) : soft_trig);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		n = s;
		n.cap.we_bram = 1'b0;
		n.cap.we_sram = 1'b0;
		// dedicated external trigger pin, two-stage sync
		n.trig_sync = {s.trig_sync[0], EXTERNAL_TRIGGER_INPUT};
		n.trig_prev = s.trig_sync[1];
		n.health_meta = HEALTH;
		n.health_sync = s.health_meta;

		// Register writes in the data phase
		if (s.write_ph) begin
			case (s.addr)
				`FAC_OFF_CTRL: begin
					n.feedback_on = AHB_REQ.hwdata[`FAC_CTRL_FB_ON];
					n.coef_set = AHB_REQ.hwdata[`FAC_CTRL_COEF];
					n.gain_shift = AHB_REQ.hwdata[`FAC_CTRL_GAIN_HI:`FAC_CTRL_GAIN_LO];
					n.coef_swap_enable = AHB_REQ.hwdata[`FAC_CTRL_SWAP];
					n.trigger_source_select = AHB_REQ.hwdata[`FAC_CTRL_TRIG_SRC];
					n.automatic_rearm = AHB_REQ.hwdata[`FAC_CTRL_REARM];
					n.capture_memory_select = AHB_REQ.hwdata[`FAC_CTRL_MEM];
				end
				`FAC_OFF_PROC_DEC: n.proc_decimation = AHB_REQ.hwdata[7:0];
				`FAC_OFF_REC_DEC: n.record_decimation = AHB_REQ.hwdata[7:0];
				`FAC_OFF_REC_LEN: n.rec_len = AHB_REQ.hwdata[23:0];
				`FAC_OFF_GROW_LEN: n.grow_len = AHB_REQ.hwdata[23:0];
				`FAC_OFF_HOLDOFF: n.holdoff = AHB_REQ.hwdata[15:0];
				`FAC_OFF_SAT_THR: n.sat_thresh = AHB_REQ.hwdata[15:0];
				default: ;
			endcase
		end

		// Address phase capture
		n.write_ph = addr_act && AHB_REQ.hwrite;
		if (addr_act) begin
			n.addr = addr_in;
		end

		// Acquisition sequencer
		unique case (s.acq)
			FAC_IDLE: begin
				if (trig_ok) begin
					n.done = 1'b0;
					n.rec_cnt = '0;
					n.phase_cnt = '0;
					if (s.coef_swap_enable && s.holdoff != 16'h0000) begin
						n.acq = FAC_HOLD;
					end else begin
						n.acq = FAC_REC;
					end
				end
			end
			FAC_HOLD: begin
				// hold-off counted in groups of four samples
				if (SAMPLE.valid) begin
					if (18'(s.phase_cnt + 18'h1) >= {s.holdoff, `FAC_HOLD_GROUP'b00}) begin
						n.acq = FAC_REC;
						n.phase_cnt = '0;
					end else begin
						n.phase_cnt = 18'(s.phase_cnt + 18'h1);
					end
				end
			end
			FAC_REC: begin
				if (s.rec_cnt >= eff_len) begin
					n.acq = FAC_IDLE;
					n.done = 1'b1;
				end else if (rec_strobe) begin
					// steer the write to the selected memory
					n.cap.we_bram = !s.capture_memory_select;
					n.cap.we_sram = s.capture_memory_select;
					n.cap.addr = s.rec_cnt[22:0];
					n.cap.data = SAMPLE.data;
					n.rec_cnt = 24'(s.rec_cnt + 24'h1);
				end
			end
		endcase

		// accepted external trigger uses up the arm
		if (trig_ok && s.trigger_source_select) begin
			n.armed = 1'b0;
		end
		if (arm_cmd || (readout_cmd && s.automatic_rearm)) begin
			n.armed = 1'b1;
		end

		// feedback output gated by the switch
		if (!s.feedback_on) begin
			n.dac_data = '0;
		end else if (proc_strobe) begin
			n.dac_data = scaled;
		end

		// Read data taken after this cycle's writes
		if (addr_act && !AHB_REQ.hwrite) begin
			n.hrdata = read_word(n, addr_in, filter_saturation_flag);
		end
	end

	// State register
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign HRDATA = s.hrdata;
	assign HREADYOUT = 1'b1;
	assign HRESP = `FAC_RESP_OKAY;
	assign DAC_DATA = s.dac_data;
	assign PROC_STROBE = proc_strobe;
	// stored set chosen by the select bit, inverted during hold-off and the first grow samples
	assign COEF_SET = s.coef_set ^ invert;
	assign CAP = s.cap;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);

	logic small_in; // Sample that cannot clamp at any shift
	assign small_in = $signed(SAMPLE.data) < 16'sh0100 && $signed(SAMPLE.data) > -16'sh0100;

	AST_FB_OFF: assert property (!s.feedback_on |=> DAC_DATA == 16'h0000) else $error("Output not withheld with feedback off");
	AST_GAIN: assert property ((proc_strobe && s.feedback_on && small_in) |=> $signed(DAC_DATA) == $signed($past(SAMPLE.data)) * (32'sd1 <<< $past(s.gain_shift))) else $error("Gain is not a power of two");
	AST_IDLE_SELECT: assert property (s.acq == FAC_IDLE |-> COEF_SET == s.coef_set) else $error("Coefficient select altered while idle");
	AST_HOLD_INVERT: assert property (s.acq == FAC_HOLD |-> COEF_SET != s.coef_set) else $error("Select not inverted during hold-off");
	AST_NO_SWAP: assert property ((s.acq == FAC_REC && !s.coef_swap_enable) |-> COEF_SET == s.coef_set) else $error("Select switched with swapping disabled");
	AST_UNARMED: assert property ((s.acq == FAC_IDLE && s.trigger_source_select && !s.armed) |=> s.acq == FAC_IDLE) else $error("Unarmed external trigger started capture");
	AST_ONE_SHOT: assert property ((trig_ok && s.trigger_source_select && !arm_cmd && !readout_cmd) |=> !s.armed) else $error("Arm not consumed by trigger");
	AST_REC_END: assert property ((s.acq == FAC_REC && s.rec_cnt >= eff_len) |=> (s.acq == FAC_IDLE && s.done)) else $error("Capture did not stop at length");
	AST_BRAM_LIMIT: assert property (CAP.we_bram |-> CAP.addr < 23'(`FAC_BRAM_LIMIT)) else $error("Block memory write beyond limit");
	AST_MEM_SEL: assert property ((rec_strobe && s.acq == FAC_REC && s.rec_cnt < eff_len) |=> (CAP.we_sram == $past(s.capture_memory_select) && CAP.we_bram != CAP.we_sram)) else $error("Capture write in wrong memory");
	AST_REARM: assert property ((readout_cmd && s.automatic_rearm) |=> s.armed) else $error("Readout did not re-arm");
endmodule

`default_nettype wire

// ### verification/fac_adc_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Filter output source model
// ----------------------------------------
module fac_adc_model (
	input wire logic SYS_CLK,
	input wire logic SLOW,
	input wire logic SAT,
	output var fac_pkg::fac_sample_s SAMPLE
);
	import fac_pkg::*;
	logic v; // Sample present this cycle
	initial SAMPLE = '0;
	// Gaps when slow; idle data is the inverse of the last word
	always @(posedge SYS_CLK) begin
		v = SLOW ? 1'($urandom_range(1, 0)) : 1'b1;
		SAMPLE.valid <= v;
		SAMPLE.saturated <= v & SAT;
		SAMPLE.data <= v ? 16'($urandom) : ~SAMPLE.data;
	end
endmodule
`default_nettype wire

// ### verification/feedback_acquisition_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "fac_defs.svh"
module feedback_acquisition_control_tb;
	import fac_pkg::*;
	// ----------------------------------------
	// Signals and scoreboard
	// ----------------------------------------
	logic clk = 0, rst = 1, slow = 0, sat = 0, etrig = 0, chk_dac = 0, rd_chk = 0, fb = 0;
	fac_ahb_req_s mreq = '0, req;
	fac_health_s health = '0;
	fac_sample_s smp;
	fac_cap_s cap;
	logic [31:0] hrdata, eq[$], mq[$];
	logic [15:0] dac, pdat = 0;
	logic hready, hresp, pstb, coef, pstb_q = 0;
	logic [2:0] g = 0;
	logic cw[8];
	int wt[8];
	int errors = 0, cmp_count = 0, cyc = 0, nb = 0, ns = 0, ps = 0, p0, b0, s0, t0;
	logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h1c, 8'h20, 8'h3c};
	// Clock and bus ready loop-back
	initial forever #4 clk = ~clk;
	always_comb begin
		req = mreq;
		req.hready = hready;
	end
	fac_top u_dut (.SYS_CLK(clk), .SYS_RST(rst), .AHB_REQ(req), .HRDATA(hrdata),
		.HREADYOUT(hready), .HRESP(hresp), .SAMPLE(smp), .DAC_DATA(dac),
		.PROC_STROBE(pstb), .COEF_SET(coef), .EXTERNAL_TRIGGER_INPUT(etrig),
		.HEALTH(health), .CAP(cap));
	fac_adc_model u_adc (.SYS_CLK(clk), .SLOW(slow), .SAT(sat), .SAMPLE(smp));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] clamp(input logic [15:0] d, input logic [2:0] s);
		logic signed [31:0] v;
		v = $signed(d) <<< s;
		if (v > 32767) return 16'h7fff;
		if (v < -32768) return 16'h8000;
		return v[15:0];
	endfunction
	// Address phase held until ready
	task addr_ph(input logic [7:0] a, input logic w);
		@(posedge clk);
		mreq.hsel <= 1'b1;
		mreq.haddr <= {24'h0, a};
		mreq.htrans <= 2'h2;
		mreq.hwrite <= w;
		mreq.hsize <= 3'h2;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		mreq.htrans <= 2'h0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		addr_ph(a, 1'b1);
		mreq.hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
	endtask
	// Read note queued, monitor compares at data end
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		addr_ph(a, 1'b0);
		eq.push_back(e & m);
		mq.push_back(m);
		rd_chk <= 1'b1;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd_chk <= 1'b0;
	endtask
	task pulse;
		@(posedge clk);
		etrig <= 1'b1;
		repeat (3) @(posedge clk);
		etrig <= 1'b0;
	endtask
	task wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task print_verdict;
		$display("errors=%0d comparisons=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Output monitor
	// ----------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rd_chk) chk(hrdata & mq.pop_front(), eq.pop_front());
		if (chk_dac && pstb_q) chk(dac, fb ? clamp(pdat, g) : 16'h0);
		pstb_q <= pstb;
		pdat <= smp.data;
		// Counters start after reset so unknown outputs never enter them
		if (!rst) begin
			ps <= ps + pstb;
			if (cap.we_bram | cap.we_sram) begin
				chk(cap.data, pdat);
				wt[cap.addr[2:0]] <= cyc;
				cw[cap.addr[2:0]] <= coef;
			end
			nb <= nb + cap.we_bram;
			ns <= ns + cap.we_sram;
		end
	end
	// Hang guard
	initial begin
		#400000;
		errors++;
		print_verdict;
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h3905));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		foreach (ra[i]) rd(ra[i], 32'h0, 32'hffffffff);
		chk(dac, 16'h0);
		chk(hresp, 1'b0);
		chk(hready, 1'b1);
		wr(`FAC_OFF_REC_LEN, 32'hffffffff);
		rd(`FAC_OFF_REC_LEN, 32'h00ffffff, 32'hffffffff);
		wr(`FAC_OFF_CTRL, 32'hffff);
		rd(`FAC_OFF_CTRL, 32'h0f1f, 32'hffffffff);
		wait_n(1);
		chk(coef, 1'b1);
		wr(`FAC_OFF_CTRL, 32'h0);
		wait_n(1);
		chk(coef, 1'b0);
		// Gain, gating and processing decimation
		wr(`FAC_OFF_PROC_DEC, 32'h3);
		for (int i = 0; i < 5; i++) begin
			g = 3'($urandom_range(7, 0));
			fb = (i != 4);
			wr(`FAC_OFF_CTRL, {27'h0, g, 1'b0, fb});
			wait_n(2);
			chk_dac = 1;
			p0 = ps;
			wait_n(30);
			chk_dac = 0;
			chk(ps - p0, 10);
		end
		// Health flags
		slow <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			health <= 4'($urandom);
			repeat (4) @(posedge clk);
			rd(`FAC_OFF_STATUS, {28'h0, health}, 32'hf);
		end
		// Saturation integrator and threshold
		slow <= 1'b0;
		wr(`FAC_OFF_SAT_THR, 32'h0);
		rd(`FAC_OFF_SAT_POLL, 32'h0, 32'h0);
		sat <= 1'b1;
		@(posedge clk);
		sat <= 1'b0;
		repeat (3) @(posedge clk);
		rd(`FAC_OFF_SAT_POLL, 32'h10, 32'h10);
		rd(`FAC_OFF_SAT_POLL, 32'h0, 32'h10);
		slow <= 1'b1;
		wr(`FAC_OFF_SAT_THR, 32'h8000);
		rd(`FAC_OFF_SAT_POLL, 32'h0, 32'h0);
		sat <= 1'b1;
		repeat (8) @(posedge clk);
		sat <= 1'b0;
		repeat (30) @(posedge clk);
		rd(`FAC_OFF_SAT_POLL, 32'h0, 32'h10);
		sat <= 1'b1;
		repeat (30) @(posedge clk);
		rd(`FAC_OFF_SAT_POLL, 32'h10, 32'h10);
		sat <= 1'b0;
		slow <= 1'b0;
		// Capture with coefficient swap, hold-off and grow
		wr(`FAC_OFF_REC_LEN, 32'h6);
		wr(`FAC_OFF_GROW_LEN, 32'h2);
		wr(`FAC_OFF_HOLDOFF, 32'h1);
		wr(`FAC_OFF_REC_DEC, 32'h0);
		wr(`FAC_OFF_CTRL, 32'h100);
		#1;
		b0 = nb;
		t0 = cyc;
		wr(`FAC_OFF_CMD, 32'h1);
		wait_n(2);
		chk(coef, 1'b1);
		wait_n(30);
		chk(nb - b0, 6);
		chk(wt[0] - t0 >= 7, 1'b1);
		chk(cw[0], 1'b1);
		chk(cw[4], 1'b0);
		chk(cap.addr, 23'h5);
		rd(`FAC_OFF_STATUS, 32'h80, 32'hc0);
		rd(`FAC_OFF_CAP_CNT, 32'h6, 32'hffffffff);
		// Capture into SRAM, swap off, own decimation
		wr(`FAC_OFF_REC_LEN, 32'h4);
		wr(`FAC_OFF_REC_DEC, 32'h2);
		wr(`FAC_OFF_CTRL, 32'h800);
		#1;
		s0 = ns;
		b0 = nb;
		wr(`FAC_OFF_CMD, 32'h1);
		wait_n(2);
		chk(coef, 1'b0);
		wait_n(30);
		chk(ns - s0, 4);
		chk(nb - b0, 0);
		chk(wt[3] - wt[0], 6);
		// External trigger, arm and one shot
		wr(`FAC_OFF_REC_LEN, 32'h2);
		wr(`FAC_OFF_REC_DEC, 32'h0);
		wr(`FAC_OFF_CTRL, 32'h200);
		#1;
		b0 = nb;
		pulse();
		wr(`FAC_OFF_CMD, 32'h1);
		wait_n(15);
		chk(nb - b0, 0);
		wr(`FAC_OFF_CMD, 32'h2);
		rd(`FAC_OFF_STATUS, 32'h20, 32'h20);
		pulse();
		wait_n(15);
		chk(nb - b0, 2);
		pulse();
		wait_n(15);
		chk(nb - b0, 2);
		wr(`FAC_OFF_CMD, 32'h4);
		rd(`FAC_OFF_STATUS, 32'h0, 32'h20);
		// Readout re-arms when enabled
		wr(`FAC_OFF_CTRL, 32'h600);
		wr(`FAC_OFF_CMD, 32'h4);
		rd(`FAC_OFF_STATUS, 32'h20, 32'h20);
		pulse();
		wait_n(15);
		chk(nb - b0, 4);
		print_verdict;
	end
endmodule
`default_nettype wire
